//--- inc/spimsp_defines.vh
/*
 * constants for the serial master/slave port: register offsets, field
 * positions, reset values and timing counts.
 * assumes a single 50 MHz clock and an 8-bit register port.
 */
// Summary of operation
// - master drives clock, full-duplex byte exchange
// - slave shifts on external clock edges
// - status bit 7 selects bit order
// - control bit 3 sets idle data level
// - status bits 6:5 select output delay
// - control bit 7 selects shifting edge
// - buffer full set after eight bits
// - byte done: load buffer, set flags
// - reading read buffer clears full flag
// - write buffer ignores writes while shifting
// - start bit loads shifter, begins shifting
// - start bit stays set until done
// - default order most significant bit first
// - baud field selects rate and source
// - slave ignores baud bits; edge bit picks its sampling edge
// - deselected slave ignores pins, releases output
// - unselected data input treated as undriven
// - both ends share rate and edge
// - select-gated operation only in slave mode
// - bit rate at most 8 MHz
`ifndef SPIMSP_DEFINES_VH
`define SPIMSP_DEFINES_VH

`define SPIMSP_ADDR_W 8
`define SPIMSP_OFS_FLAGS 8'h17
`define SPIMSP_OFS_MASK 8'h1e
`define SPIMSP_OFS_CTRL 8'h36
`define SPIMSP_OFS_STAT 8'h37
`define SPIMSP_OFS_RBUF 8'h38
`define SPIMSP_OFS_WBUF 8'h39

// control register fields
`define SPIMSP_CTRL_EDGE 7
`define SPIMSP_CTRL_SLAVE 6
`define SPIMSP_CTRL_SSEN 5
`define SPIMSP_CTRL_START 4
`define SPIMSP_CTRL_IDLE 3
// status register fields
`define SPIMSP_STAT_ORDER 7
`define SPIMSP_STAT_DLYH 6
`define SPIMSP_STAT_DLYL 5
`define SPIMSP_STAT_RBF 0
// flag / mask bit
`define SPIMSP_FLAG_DONE 3

`define SPIMSP_CTRL_RST 8'h00
`define SPIMSP_STAT_RST 8'h00

// timing
`define SPIMSP_CLK_MHZ 50
`define SPIMSP_MAX_BIT_MHZ 8
// fastest half period: ceil(50/(2*8)) = 4 counts, five cycles per half, keeps the bit rate under 8 MHz
`define SPIMSP_MIN_HALF ((`SPIMSP_CLK_MHZ + 2 * `SPIMSP_MAX_BIT_MHZ - 1) / (2 * `SPIMSP_MAX_BIT_MHZ))
// output delay step in clock cycles
`define SPIMSP_DLY_STEP 2

`endif

//--- verilog/spimsp_port.v
/*
 * serial master/slave port: byte shifter with master clock generator,
 * slave edge detection on sampled pins, and an 8-bit register port.
 * assumes pins are asynchronous to clock_i; the register master follows
 * the single-cycle strobe protocol with read data one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none
`include "spimsp_defines.vh"

module spimsp_port
#(
    parameter DATA_W = 8
)
(
    input wire clock_i,
    input wire rstn_i,
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    input wire sck_i,
    output reg sck_o,
    output reg sck_oe_o,
    input wire sdi_i,
    output reg sdo_o,
    output reg sdo_oe_o,
    input wire ss_n_i,
    input wire ext_clk_i,
    output wire irq_o
);

    // engine states
    localparam ST_IDLE = 2'b00;
    localparam ST_SHIFT = 2'b01;
    localparam ST_DONE = 2'b10;
    localparam [7:0] MIN_HALF = `SPIMSP_MIN_HALF;

    // control / status storage
    reg edge_sel;
    reg slave_mode;
    reg ss_enable;
    reg shift_start_busy;
    reg output_idle_control;
    reg [2:0] baud_rate_select;
    reg transfer_order_select;
    reg [1:0] out_delay;
    reg read_buffer_full;
    reg transfer_done_flag;
    reg transfer_done_irq_enable;
    reg [DATA_W-1:0] serial_read_buffer;
    reg [DATA_W-1:0] serial_write_buffer;

    // engine
    reg [1:0] state;
    reg [DATA_W-1:0] shifter;
    reg [3:0] bit_cnt;
    reg [7:0] div_cnt;
    reg [3:0] dly_cnt;
    reg dly_pend;
    reg dly_bit;

    // three-stage samplers for pins
    reg [2:0] sck_s;
    reg [2:0] sdi_s;
    reg [2:0] ss_s;
    reg [2:0] ext_s;
    reg sck_lvl;
    reg sdi_lvl;
    reg ss_lvl;
    reg ext_lvl;

    // reload count, one less than the half period in cycles, for each baud code; code 7 uses external clock
    function [7:0] half_of;
        input [2:0] code;
        begin
            case (code)
                3'h0: half_of = MIN_HALF;
                3'h1: half_of = MIN_HALF * 8'h02;
                3'h2: half_of = MIN_HALF * 8'h04;
                3'h3: half_of = MIN_HALF * 8'h08;
                3'h4: half_of = MIN_HALF * 8'h10;
                3'h5: half_of = 8'h7d;
                3'h6: half_of = 8'hfa;
                default: half_of = MIN_HALF;
            endcase
        end
    endfunction

    // bit to present next, by selected order
    function out_bit;
        input [DATA_W-1:0] v;
        input lsb_first;
        begin
            out_bit = lsb_first ? v[0] : v[DATA_W-1];
        end
    endfunction

    // delay count for the data output, two cycles per step; the longest delay outlasts the fastest half period
    function [3:0] dly_of;
        input [1:0] steps;
        begin
            dly_of = {1'b0, steps, 1'b0};
        end
    endfunction

    // shifter after taking one sampled bit, by selected order
    function [DATA_W-1:0] shift_in;
        input [DATA_W-1:0] v;
        input b;
        input lsb_first;
        begin
            shift_in = lsb_first ? {b, v[DATA_W-1:1]} : {v[DATA_W-2:0], b};
        end
    endfunction

    // a level change counts once stages two and three agree
    always @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sck_s <= 3'h0;
            sdi_s <= 3'h7;
            ss_s <= 3'h7;
            ext_s <= 3'h0;
            sck_lvl <= 1'b0;
            sdi_lvl <= 1'b1;
            ss_lvl <= 1'b1;
            ext_lvl <= 1'b0;
        end
        else
        begin
            sck_s <= {sck_s[1:0], sck_i};
            sdi_s <= {sdi_s[1:0], sdi_i};
            ss_s <= {ss_s[1:0], ss_n_i};
            ext_s <= {ext_s[1:0], ext_clk_i};
            if (sck_s[1] == sck_s[2])
                sck_lvl <= sck_s[2];
            if (sdi_s[1] == sdi_s[2])
                sdi_lvl <= sdi_s[2];
            if (ss_s[1] == ss_s[2])
                ss_lvl <= ss_s[2];
            if (ext_s[1] == ext_s[2])
                ext_lvl <= ext_s[2];
        end
    end

    // edge events from the filtered levels
    reg sck_prev;
    reg ext_prev;
    wire sck_rise = sck_lvl & ~sck_prev;
    wire sck_fall = ~sck_lvl & sck_prev;
    wire ext_tick = ext_lvl & ~ext_prev;
    wire use_ext = (baud_rate_select == 3'h7);
    wire half_done = use_ext ? ext_tick : (div_cnt == 8'h00);
    // slave with select enabled is gated by the select pin
    wire slave_sel = ~ss_enable | ~ss_lvl;
    // leading (sample) and trailing (shift-out) edges; edge bit matters to master and slave
    wire m_lead = ~sck_o ^ edge_sel;
    wire s_sample = slave_sel & sck_rise;
    wire s_shift = slave_sel & sck_fall;
    // unselected input reads as released line
    wire sdi_eff = slave_mode & ~slave_sel ? 1'b1 : sdi_lvl;
    wire byte_end = (bit_cnt == 4'd8);

    // register decode
    wire wr_ctrl = wr_i && addr_i == `SPIMSP_OFS_CTRL;
    wire start_req = wr_ctrl && wdata_i[`SPIMSP_CTRL_START] && state == ST_IDLE;
    wire rbuf_read = rd_i && addr_i == `SPIMSP_OFS_RBUF;

    // shift engine
    always @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state <= ST_IDLE;
            shifter <= {DATA_W{1'b0}};
            bit_cnt <= 4'h0;
            div_cnt <= 8'h00;
            sck_o <= 1'b0;
            sck_prev <= 1'b0;
            ext_prev <= 1'b0;
            dly_cnt <= 4'h0;
            dly_pend <= 1'b0;
            dly_bit <= 1'b0;
            sdo_o <= 1'b0;
        end
        else
        begin
            sck_prev <= sck_lvl;
            ext_prev <= ext_lvl;
            // delayed data output: delay of out_delay steps
            if (dly_pend)
            begin
                if (dly_cnt == 4'h0)
                begin
                    sdo_o <= dly_bit;
                    dly_pend <= 1'b0;
                end
                else
                    dly_cnt <= dly_cnt - 4'h1;
            end
            case (state)
                ST_IDLE:
                begin
                    // idle: master clock parked at the level the edge bit asks for; held low in slave mode
                    sck_o <= edge_sel & ~slave_mode;
                    if (start_req)
                    begin
                        // first bit goes out after the output delay, before the first clock edge only if that delay is shorter than the half period
                        shifter <= serial_write_buffer;
                        bit_cnt <= 4'h0;
                        div_cnt <= half_of(baud_rate_select);
                        state <= ST_SHIFT;
                        dly_bit <= out_bit(serial_write_buffer, transfer_order_select);
                        dly_cnt <= dly_of(out_delay);
                        dly_pend <= 1'b1;
                    end
                end
                ST_SHIFT:
                begin
                    if (!slave_mode)
                    begin
                        // master clock generator; the sampled input lags the pin by four cycles,
                        // so the five-cycle fastest half period still catches each new bit
                        div_cnt <= half_done ? half_of(baud_rate_select) : div_cnt - 8'h01;
                        if (half_done)
                        begin
                            sck_o <= ~sck_o;
                            if (m_lead)
                            begin
                                // first edge of each clock cycle: sample
                                shifter <= shift_in(shifter, sdi_eff, transfer_order_select);
                                bit_cnt <= bit_cnt + 4'h1;
                            end
                            else if (bit_cnt == 4'd8)
                            begin
                                // sixteenth half period brings the clock back to idle: byte complete
                                state <= ST_DONE;
                            end
                            else if (bit_cnt != 4'h0)
                            begin
                                dly_bit <= out_bit(shifter, transfer_order_select);
                                dly_cnt <= dly_of(out_delay);
                                dly_pend <= 1'b1;
                            end
                        end
                    end
                    // slave: pin edges pace the shifter, edge bit picks the sampling edge
                    else if (edge_sel ? s_shift : s_sample)
                    begin
                        shifter <= shift_in(shifter, sdi_eff, transfer_order_select);
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    else if ((s_sample | s_shift) && bit_cnt != 4'h0)
                    begin
                        dly_bit <= out_bit(shifter, transfer_order_select);
                        dly_cnt <= dly_of(out_delay);
                        dly_pend <= 1'b1;
                    end
                    // slave ends on the eighth sample; the master waits for the idle edge above
                    if (slave_mode && byte_end)
                        state <= ST_DONE;
                end
                default:
                begin
                    // byte complete: settle the data line as programmed
                    sdo_o <= output_idle_control;
                    dly_pend <= 1'b0;
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // pin drivers: slave releases data when not selected
    always @*
    begin
        sck_oe_o = ~slave_mode;
        sdo_oe_o = ~slave_mode | slave_sel;
    end

    // register writes, flags; hardware set wins over software clear
    wire done_evt = (state == ST_DONE);
    always @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            edge_sel <= 1'b0;
            slave_mode <= 1'b0;
            ss_enable <= 1'b0;
            shift_start_busy <= 1'b0;
            output_idle_control <= 1'b0;
            baud_rate_select <= 3'h0;
            transfer_order_select <= 1'b0;
            out_delay <= 2'h0;
            read_buffer_full <= 1'b0;
            transfer_done_flag <= 1'b0;
            transfer_done_irq_enable <= 1'b0;
            serial_read_buffer <= {DATA_W{1'b0}};
            serial_write_buffer <= {DATA_W{1'b0}};
        end
        else
        begin
            if (wr_ctrl && !shift_start_busy)
            begin
                edge_sel <= wdata_i[`SPIMSP_CTRL_EDGE];
                slave_mode <= wdata_i[`SPIMSP_CTRL_SLAVE];
                ss_enable <= wdata_i[`SPIMSP_CTRL_SSEN];
                output_idle_control <= wdata_i[`SPIMSP_CTRL_IDLE];
                baud_rate_select <= wdata_i[2:0];
            end
            // order and delay are frozen while a byte is moving
            if (wr_i && addr_i == `SPIMSP_OFS_STAT && !shift_start_busy)
            begin
                transfer_order_select <= wdata_i[`SPIMSP_STAT_ORDER];
                out_delay <= wdata_i[`SPIMSP_STAT_DLYH:`SPIMSP_STAT_DLYL];
            end
            // write buffer refuses new bytes while shifting
            if (wr_i && addr_i == `SPIMSP_OFS_WBUF && !shift_start_busy)
                serial_write_buffer <= wdata_i;
            // interrupt enable is always writable
            if (wr_i && addr_i == `SPIMSP_OFS_MASK)
                transfer_done_irq_enable <= wdata_i[`SPIMSP_FLAG_DONE];
            // busy bit follows the engine
            if (start_req)
                shift_start_busy <= 1'b1;
            else if (done_evt)
                shift_start_busy <= 1'b0;
            if (done_evt)
                serial_read_buffer <= shifter;
            // full flag: set on completion, cleared by buffer read
            if (done_evt)
                read_buffer_full <= 1'b1;
            else if (rbuf_read || (wr_i && addr_i == `SPIMSP_OFS_STAT && !wdata_i[`SPIMSP_STAT_RBF]))
                read_buffer_full <= 1'b0;
            // done flag: set on completion, cleared by writing zero
            if (done_evt)
                transfer_done_flag <= 1'b1;
            else if (wr_i && addr_i == `SPIMSP_OFS_FLAGS && !wdata_i[`SPIMSP_FLAG_DONE])
                transfer_done_flag <= 1'b0;
        end
    end

    assign irq_o = transfer_done_flag & transfer_done_irq_enable;

    // read data registered one cycle after the strobe; unmapped reads zero
    always @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rdata_o <= 8'h00;
        end
        else
        begin
            rdata_o <= 8'h00;
            if (rd_i)
            begin
                case (addr_i)
                    `SPIMSP_OFS_CTRL: rdata_o <= {edge_sel, slave_mode, ss_enable, shift_start_busy,
                                                  output_idle_control, baud_rate_select};
                    `SPIMSP_OFS_STAT: rdata_o <= {transfer_order_select, out_delay, 4'h0, read_buffer_full};
                    `SPIMSP_OFS_RBUF: rdata_o <= serial_read_buffer;
                    `SPIMSP_OFS_WBUF: rdata_o <= serial_write_buffer;
                    `SPIMSP_OFS_FLAGS: rdata_o <= {4'h0, transfer_done_flag, 3'h0};
                    `SPIMSP_OFS_MASK: rdata_o <= {4'h0, transfer_done_irq_enable, 3'h0};
                    default: rdata_o <= 8'h00;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

//--- testbench/spimsp_chk.sv
/*
 * port checker for the serial port: register bus, clock pin and interrupt.
 * assumes it is bound to spimsp_port and sees its ports only.
 */
`timescale 1ns/1ps
`default_nettype none
`include "spimsp_defines.vh"
module spimsp_chk (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic sck_o,
    input wire logic sck_oe_o,
    input wire logic sdo_oe_o,
    input wire logic irq_o
);
    logic mask_en;
    // shadow of the enable bit, so irq can be judged without the flag itself
    always @(posedge clock_i or negedge rstn_i)
        if (!rstn_i) mask_en <= 1'b0;
        else if (wr_i && addr_i == `SPIMSP_OFS_MASK) mask_en <= wdata_i[`SPIMSP_FLAG_DONE];
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    property p_rd_pulse; !rd_i |=> rdata_o == 8'h00; endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read data outside read slot");
    property p_unmapped; rd_i && !(addr_i inside {8'h17, 8'h1e, 8'h36, 8'h37, 8'h38, 8'h39})
        |=> rdata_o == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_irq_gate; irq_o |-> mask_en; endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq while masked");
    property p_mask_rb; wr_i && addr_i == `SPIMSP_OFS_MASK ##2 rd_i && addr_i == `SPIMSP_OFS_MASK
        |=> rdata_o[3] == $past(wdata_i[3], 3); endproperty
    a_mask_rb: assert property (p_mask_rb) else $error("mask readback wrong");
    property p_sck_hold; $changed(sck_o) |=> $stable(sck_o)[*3]; endproperty
    a_sck_hold: assert property (p_sck_hold) else $error("serial clock half period too short");
    property p_sck_slave; !sck_oe_o ##1 !sck_oe_o |-> $stable(sck_o); endproperty
    a_sck_slave: assert property (p_sck_slave) else $error("clock moves in slave mode");
    property p_oe_pair; sck_oe_o |-> sdo_oe_o; endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("master not driving data");
    property p_start_sck; wr_i && addr_i == `SPIMSP_OFS_CTRL && wdata_i[7:4] == 4'h1 && wdata_i[2:0] == 3'h0
        |-> ##[1:20] $changed(sck_o); endproperty
    a_start_sck: assert property (p_start_sck) else $error("start gave no clock");
endmodule
bind spimsp_port spimsp_chk u_chk (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .sdo_oe_o(sdo_oe_o),
    .irq_o(irq_o));
`default_nettype wire

//--- testbench/spimsp_slave_model.sv
/*
 * far-side slave: sends a loaded byte, captures the master's byte.
 * assumes clock idles low and both ends sample on the rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module spimsp_slave_model (
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic lsb_first_i,
    input wire logic [7:0] tx_i,
    input wire logic load_i,
    output logic miso_o,
    output logic [7:0] rx_o
);
    int idx = 8;
    logic [7:0] tx;
    initial miso_o = 1'b0;
    // first bit must stand before the first rising edge
    always @(posedge load_i)
    begin
        tx = tx_i;
        idx = 0;
        rx_o = 8'h00;
        miso_o = lsb_first_i ? tx_i[0] : tx_i[7];
    end
    // sample on the same edge as the master
    always @(posedge sck_i)
    begin
        rx_o = lsb_first_i ? {mosi_i, rx_o[7:1]} : {rx_o[6:0], mosi_i};
        idx = idx + 1;
    end
    // shift on falling edge; once done, show the inverse so stale data never looks valid
    always @(negedge sck_i)
        if (idx < 8) miso_o = lsb_first_i ? tx[idx] : tx[7 - idx];
        else miso_o = ~miso_o;
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
/*
 * testbench for the serial port: register access, master and slave bytes.
 * assumes the slave model on the far side and a 50 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "spimsp_defines.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; $display("unexpected %0t compare mismatch", $time); end end
module tb_top;
    logic clock_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, ss_n_i = 1, slv = 0, sck_tb = 0, sdi_tb = 1;
    logic load = 0, lsbm = 0;
    logic [7:0] addr_i = 0, wdata_i = 0, mtx = 0, v, got, sb = 8'hc3;
    wire logic [7:0] rdata_o, mrx;
    wire logic sck_o, sck_oe_o, sdo_o, sdo_oe_o, irq_o, miso;
    // resolved clock pin and data input source
    wire logic sck_w = sck_oe_o ? sck_o : sck_tb;
    wire logic sdi_w = slv ? sdi_tb : miso;
    int bad_count = 0, num_checks = 0, cyc = 0;
    spimsp_port u_dut (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .sdi_i(sdi_w),
        .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .ss_n_i(ss_n_i), .ext_clk_i(1'b0), .irq_o(irq_o));
    spimsp_slave_model u_slave (.sck_i(sck_w), .mosi_i(sdo_o), .lsb_first_i(lsbm), .tx_i(mtx),
        .load_i(load), .miso_o(miso), .rx_o(mrx));
    initial forever #10 clock_i = ~clock_i;
    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // hang guard, far above the few hundred cycles the tests need
    always @(posedge clock_i)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            bad_count++;
            give_verdict;
        end
    end
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1;
        @(posedge clock_i);
        wr_i <= 0;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1;
        @(posedge clock_i);
        rd_i <= 0;
        #1 d = rdata_o;
    endtask
    // poll the busy bit under a bound
    task wait_idle;
        repeat (300)
        begin
            rd(`SPIMSP_OFS_CTRL, v);
            if (v[4] === 1'b0) break;
        end
        `CHK(v[4], 1'b0)
    endtask
    task run_master(input logic [7:0] st, input logic [7:0] wb, input logic [7:0] tx, input logic [7:0] ct);
        slv <= 0;
        lsbm <= st[7];
        wr(`SPIMSP_OFS_STAT, st);
        wr(`SPIMSP_OFS_WBUF, wb);
        mtx <= tx;
        load <= 1;
        wr(`SPIMSP_OFS_CTRL, ct);
        load <= 0;
        rd(`SPIMSP_OFS_CTRL, v);
        `CHK(v[4], 1'b1)
        wr(`SPIMSP_OFS_WBUF, 8'hff);
        rd(`SPIMSP_OFS_WBUF, v);
        `CHK(v, wb)
        wait_idle;
        rd(`SPIMSP_OFS_STAT, v);
        `CHK(v[0], 1'b1)
        rd(`SPIMSP_OFS_FLAGS, v);
        `CHK(v[3], 1'b1)
        rd(`SPIMSP_OFS_RBUF, v);
        `CHK(v, tx)
        `CHK(mrx, wb)
        rd(`SPIMSP_OFS_STAT, v);
        `CHK(v[0], 1'b0)
        `CHK(sdo_o, ct[3])
        wr(`SPIMSP_OFS_MASK, 8'h08);
        #1 `CHK(irq_o, 1'b1)
        wr(`SPIMSP_OFS_MASK, 8'h00);
        #1 `CHK(irq_o, 1'b0)
        wr(`SPIMSP_OFS_FLAGS, 8'h00);
    endtask
    task test_regs;
        rd(`SPIMSP_OFS_CTRL, v);
        `CHK(v, `SPIMSP_CTRL_RST)
        rd(`SPIMSP_OFS_STAT, v);
        `CHK(v, `SPIMSP_STAT_RST)
        rd(8'h00, v);
        `CHK(v, 8'h00)
        wr(`SPIMSP_OFS_MASK, 8'h08);
        rd(`SPIMSP_OFS_MASK, v);
        `CHK(v[3], 1'b1)
        wr(`SPIMSP_OFS_MASK, 8'h00);
        $display("test_regs done");
    endtask
    task test_msb;
        run_master(8'h00, 8'ha5, 8'h3c, 8'h10);
        $display("test_msb done");
    endtask
    // lsb first with a two-cycle output delay
    task test_lsb;
        run_master(8'ha0, 8'h12, 8'hc4, 8'h10);
        $display("test_lsb done");
    endtask
    task test_idle;
        run_master(8'h00, 8'h00, 8'h81, 8'h18);
        $display("test_idle done");
    endtask
    // slave with select gating, link clock driven only inside the frame
    task test_slave;
        slv <= 1;
        wr(`SPIMSP_OFS_CTRL, 8'h60);
        #1 `CHK(sdo_oe_o, 1'b0)
        wr(`SPIMSP_OFS_WBUF, 8'h5a);
        wr(`SPIMSP_OFS_CTRL, 8'h70);
        ss_n_i <= 0;
        repeat (4) @(posedge clock_i);
        // 160 ns link period: four clock cycles per half, data read just before the falling edge
        for (int i = 7; i >= 0; i--)
        begin
            sdi_tb <= sb[i];
            repeat (4) @(posedge clock_i);
            sck_tb <= 1;
            repeat (4) @(posedge clock_i);
            got[i] = sdo_o;
            sck_tb <= 0;
        end
        sdi_tb <= ~sdi_tb;
        repeat (8) @(posedge clock_i);
        ss_n_i <= 1;
        `CHK(got, 8'h5a)
        wait_idle;
        rd(`SPIMSP_OFS_RBUF, v);
        `CHK(v, sb)
        $display("test_slave done");
    endtask
    initial
    begin
        repeat (8) @(posedge clock_i);
        rstn_i <= 1;
        repeat (4) @(posedge clock_i);
        test_regs;
        test_msb;
        test_lsb;
        test_idle;
        test_slave;
        give_verdict;
    end
endmodule
`default_nettype wire
